// ==== design/ocr_oscillator_control_regs.sv ====
// oscillator enable, status, fault monitor and trim register block
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module ocr_oscillator_control_regs
	import ocr_pkg::*;
#(
	parameter int XTAL_16K_CYCLES = START_16K,
	parameter int FAIL_CYCLES = EXT_FAIL_CYCLES
)
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] rdData,
	// system context, same clock domain
	input wire logic [2:0] sysClkSel,
	input wire logic ccpOpen,
	input wire logic [7:0] factoryTrim,
	// analog status pins, asynchronous
	input wire logic pllLockRaw,
	input wire logic extClkRaw,
	input wire logic [2:0] rcStableRaw,
	// oscillator enables
	output logic pllOn,
	output logic extSourceOn,
	output logic slowRcOn,
	output logic fastRcOn,
	output logic baseRcOn,
	// external oscillator settings and slow rc trim
	output logic [1:0] crystalBand,
	output logic watchCrystalLowSwing,
	output logic crystalHighDrive,
	output logic [3:0] extSourceType,
	output logic [7:0] slowRcTrimValue,
	// pll settings
	output logic [1:0] pllInputSelect,
	output logic pllHalfOutput,
	output logic [4:0] pllMultiplier,
	// fault reporting
	output logic nmiRequest,
	output logic fallbackRequest
);

	typedef struct packed {
		logic [4:0] sync1;
		logic [4:0] sync2;
		logic [4:0] sync3;
		logic [4:0] filt;
		logic extPrev;
		logic [7:0] enable;
		logic [1:0] band;
		logic lowSwing;
		logic highDrive;
		logic [3:0] extType;
		logic [7:0] trim;
		logic trimLoaded;
		logic [1:0] pll_input_select;
		logic pllHalf;
		logic [4:0] pllMult;
		logic pll_locked_flag;
		logic [2:0] rcRdy;
		ocr_ext_state_t extState;
		logic [15:0] startCnt;
		logic [15:0] gapCnt;
		logic pllWatch;
		logic pllFlag;
		logic extWatch;
		logic extFlag;
		logic nmi;
		logic fallback;
		logic [7:0] rdData;
	} ocr_state_t;

	ocr_state_t st_ff;
	ocr_state_t nxt_st;

	logic extEdge;
	logic pllFailEv;
	logic extFailEv;
	logic [15:0] startLimit;
	logic [7:0] readByte;

	// decode shared by the write and read paths
	function automatic logic regHit(input logic [3:0] a,
		input logic [3:0] off);
		regHit = (a == off);
	endfunction : regHit

	// start-up length for each source type, unknown codes get the 16k crystal count
	function automatic logic [15:0] startupCount(input logic [3:0] t);
		case (t)
			TYPE_EXTCLK: startupCount = 16'(START_EXTCLK);
			TYPE_WATCH: startupCount = 16'(XTAL_16K_CYCLES);
			TYPE_XTAL_256: startupCount = 16'(START_256);
			TYPE_XTAL_1K: startupCount = 16'(START_1K);
			TYPE_XTAL_16K: startupCount = 16'(XTAL_16K_CYCLES);
			default: startupCount = 16'(XTAL_16K_CYCLES);
		endcase
	endfunction : startupCount

	// failure events; the monitors only act while watched
	// >= so a monitor switched on late still catches a long-dead source
	always_comb
	begin
		extEdge = st_ff.filt[1] & ~st_ff.extPrev;
		startLimit = startupCount(st_ff.extType);
		pllFailEv = st_ff.pllWatch & st_ff.pll_locked_flag & st_ff.enable[BIT_PLL]
			& ~st_ff.filt[0];
		extFailEv = st_ff.extWatch & (st_ff.extState == EXT_READY)
			& ~extEdge
			& (st_ff.gapCnt >= 16'(FAIL_CYCLES - 1));
	end

	// read mux, reserved bits read as zero
	always_comb
	begin
		readByte = 8'h00;
		if (regHit(addr, OFF_ENABLE))
			readByte = st_ff.enable;
		else if (regHit(addr, OFF_STATUS))
			readByte = {3'h0, st_ff.pll_locked_flag, st_ff.extState == EXT_READY,
				st_ff.rcRdy};
		else if (regHit(addr, OFF_EXTCFG))
			readByte = {st_ff.band, st_ff.lowSwing, st_ff.highDrive,
				st_ff.extType};
		else if (regHit(addr, OFF_FAULT))
			readByte = {4'h0, st_ff.pllFlag, st_ff.pllWatch, st_ff.extFlag,
				st_ff.extWatch};
		else if (regHit(addr, OFF_TRIM))
			readByte = st_ff.trim;
		else if (regHit(addr, OFF_PLL))
			readByte = {st_ff.pll_input_select, st_ff.pllHalf, st_ff.pllMult};
	end

	// next state of the whole block
	always_comb
	begin
		nxt_st = st_ff;
		// pin synchronisers: a change counts once stages two and three agree
		nxt_st.sync1 = {rcStableRaw, extClkRaw, pllLockRaw};
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.sync3 = st_ff.sync2;
		for (int i = 0; i < 5; i++)
		begin
			if (st_ff.sync2[i] == st_ff.sync3[i])
				nxt_st.filt[i] = st_ff.sync3[i];
		end
		nxt_st.extPrev = st_ff.filt[1];

		// factory trim is taken on the first edge after reset release
		if (!st_ff.trimLoaded)
		begin
			nxt_st.trim = factoryTrim;
			nxt_st.trimLoaded = 1'b1;
		end

		// register writes; reserved bits are never stored
		if (wrStrobe)
		begin
			if (regHit(addr, OFF_ENABLE))
				nxt_st.enable = wrData & ENABLE_MASK;
			if (regHit(addr, OFF_EXTCFG))
			begin
				nxt_st.band = wrData[7:6];
				nxt_st.lowSwing = wrData[5];
				nxt_st.highDrive = wrData[4];
				// retyping a running system clock source would kill it
				if (sysClkSel != SEL_XOSC)
					nxt_st.extType = wrData[3:0];
			end
			if (regHit(addr, OFF_FAULT))
			begin
				if (wrData[BIT_PLL_FLAG])
					nxt_st.pllFlag = 1'b0;
				if (wrData[BIT_EXT_FLAG])
					nxt_st.extFlag = 1'b0;
				if (ccpOpen)
				begin
					nxt_st.pllWatch = wrData[BIT_PLL_WATCH];
					// the external monitor can only be switched on
					nxt_st.extWatch = st_ff.extWatch
						| wrData[BIT_EXT_WATCH];
				end
			end
			if (regHit(addr, OFF_TRIM))
				nxt_st.trim = wrData;
			if (regHit(addr, OFF_PLL))
			begin
				// the reserved input code leaves the old choice in place
				if (wrData[7:6] != PLL_SRC_RESERVED)
					nxt_st.pll_input_select = wrData[7:6];
				nxt_st.pllHalf = wrData[5];
				nxt_st.pllMult = wrData[4:0];
			end
		end

		// failures: fallback if it was the system clock, else just stop it
		nxt_st.fallback = 1'b0;
		if (pllFailEv)
		begin
			nxt_st.pllFlag = 1'b1;
			if (sysClkSel == SEL_PLL)
			begin
				nxt_st.enable = ENABLE_RESET;
				nxt_st.fallback = 1'b1;
			end
			else
				nxt_st.enable[BIT_PLL] = 1'b0;
		end
		if (extFailEv)
		begin
			nxt_st.extFlag = 1'b1;
			if (sysClkSel == SEL_XOSC)
			begin
				nxt_st.enable = ENABLE_RESET;
				nxt_st.fallback = 1'b1;
			end
			else
				nxt_st.enable[BIT_EXT] = 1'b0;
		end
		// a pll loss seen while watched also clears the pll enable
		if (pllFailEv)
			nxt_st.enable[BIT_PLL] = 1'b0;

		// ready flags follow the enable and the stable pins
		nxt_st.pll_locked_flag = st_ff.enable[BIT_PLL] & st_ff.filt[0]
			& ~pllFailEv;
		for (int i = 0; i < 3; i++)
			nxt_st.rcRdy[i] = st_ff.enable[i] & st_ff.filt[i + 2];

		// external start-up counts edges of the source itself
		case (st_ff.extState)
			EXT_OFF:
			begin
				nxt_st.startCnt = 16'h0000;
				nxt_st.gapCnt = 16'h0000;
				if (st_ff.enable[BIT_EXT])
					nxt_st.extState = EXT_STARTING;
			end
			EXT_STARTING:
			begin
				if (!st_ff.enable[BIT_EXT])
					nxt_st.extState = EXT_OFF;
				else if (st_ff.startCnt >= startLimit)
					nxt_st.extState = EXT_READY;
				else if (extEdge)
					nxt_st.startCnt = st_ff.startCnt + 16'h0001;
			end
			EXT_READY:
			begin
				if (!st_ff.enable[BIT_EXT] || extFailEv)
					nxt_st.extState = EXT_OFF;
				else if (extEdge)
					nxt_st.gapCnt = 16'h0000;
				else if (st_ff.gapCnt != 16'hffff)
					nxt_st.gapCnt = st_ff.gapCnt + 16'h0001;
			end
			default:
				nxt_st.extState = EXT_OFF;
		endcase

		// nmi level while a watched flag stands
		nxt_st.nmi = (nxt_st.pllFlag & nxt_st.pllWatch)
			| (nxt_st.extFlag & nxt_st.extWatch);
		// read data stand only in the cycle after the strobe
		nxt_st.rdData = rdStrobe ? readByte : 8'h00;
	end

	// state register
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_ff <= '0;
			st_ff.enable <= ENABLE_RESET;
			st_ff.band <= EXTCFG_RESET[7:6];
			st_ff.extType <= EXTCFG_RESET[3:0];
			st_ff.trim <= TRIM_RESET;
			st_ff.pll_input_select <= PLL_RESET[7:6];
			st_ff.extState <= EXT_OFF;
		end
		else
			st_ff <= nxt_st;
	end

	// outputs straight from the state register
	assign rdData = st_ff.rdData;
	assign pllOn = st_ff.enable[BIT_PLL];
	assign extSourceOn = st_ff.enable[BIT_EXT];
	assign slowRcOn = st_ff.enable[2];
	assign fastRcOn = st_ff.enable[1];
	assign baseRcOn = st_ff.enable[0];
	assign crystalBand = st_ff.band;
	assign watchCrystalLowSwing = st_ff.lowSwing;
	assign crystalHighDrive = st_ff.highDrive;
	assign extSourceType = st_ff.extType;
	assign slowRcTrimValue = st_ff.trim;
	assign pllInputSelect = st_ff.pll_input_select;
	assign pllHalfOutput = st_ff.pllHalf;
	assign pllMultiplier = st_ff.pllMult;
	assign nmiRequest = st_ff.nmi;
	assign fallbackRequest = st_ff.fallback;

	// bus steps used by the enable-write and status-read checks
	sequence s_write_enable;
		wrStrobe && regHit(addr, OFF_ENABLE) && !pllFailEv && !extFailEv;
	endsequence

	sequence s_read_status;
		rdStrobe && regHit(addr, OFF_STATUS);
	endsequence

	a_pll_enable_bit: assert property (
		@(posedge clk) disable iff (!reset_n)
		s_write_enable |=> pllOn == $past(wrData[BIT_PLL])
			&& baseRcOn == $past(wrData[0]))
		else $error("pll or base enable did not follow the write");

	a_status_read: assert property (
		@(posedge clk) disable iff (!reset_n)
		s_read_status |=> rdData[7:5] == 3'h0
			&& rdData[4] == $past(st_ff.pll_locked_flag))
		else $error("status read returned wrong data");

	a_ready_needs_on: assert property (
		@(posedge clk) disable iff (!reset_n)
		(!pllOn && !extSourceOn) |=> !st_ff.pll_locked_flag
			&& st_ff.extState != EXT_READY)
		else $error("ready flag stands with its oscillator off");

	a_type_frozen: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wrStrobe && regHit(addr, OFF_EXTCFG) && sysClkSel == SEL_XOSC)
			|=> $stable(extSourceType))
		else $error("type changed while external source is system clock");

	a_pll_flag_clear: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wrStrobe && regHit(addr, OFF_FAULT) && wrData[BIT_PLL_FLAG]
			&& !pllFailEv) |=> !st_ff.pllFlag)
		else $error("pll fault flag not cleared by writing one");

	a_watch_sticky: assert property (
		@(posedge clk) disable iff (!reset_n)
		st_ff.extWatch |=> st_ff.extWatch [*2])
		else $error("external monitor enable dropped before reset");

	a_protect_guard: assert property (
		@(posedge clk) disable iff (!reset_n)
		(wrStrobe && regHit(addr, OFF_FAULT) && !ccpOpen)
			|=> $stable(st_ff.pllWatch) && $stable(st_ff.extWatch))
		else $error("watch enable changed without protected write");

	a_nmi_follows: assert property (
		@(posedge clk) disable iff (!reset_n)
		pllFailEv |-> ##1 (st_ff.pllFlag && nmiRequest))
		else $error("pll fault did not raise flag and nmi");

	a_fallback_base: assert property (
		@(posedge clk) disable iff (!reset_n)
		((pllFailEv && sysClkSel == SEL_PLL)
			|| (extFailEv && sysClkSel == SEL_XOSC))
			|=> fallbackRequest && baseRcOn && !pllOn && !extSourceOn
			##1 !fallbackRequest)
		else $error("failing system clock did not fall back to 2mhz");

endmodule : ocr_oscillator_control_regs

// ==== design/ocr_pkg.sv ====
// constants, codes and the register map of the oscillator control block
// What this block does
// - control bit 4 switches the pll on, clearing it switches it off
// - control bit 3 starts the external source chosen by the type field
// - control bits 2,1,0 enable the 32.768khz, 32mhz and 2mhz oscillators
// - after reset the 2mhz oscillator runs and its enable reads one
// - status bit 4 sets once the pll has locked
// - status bit 3 sets once the external source has stabilised
// - status bits 2..0 report rc stability, read-only, reset 0
// - band field 7:6 picks crystal range 0.4-2, 2-9, 9-12, 12-16 mhz
// - config bit 5 puts the watch crystal into reduced-swing low power
// - config bit 4 raises the drive current of the main crystal
// - type 0000 external clock 6 cycles, 0010 watch crystal 16k cycles
// - types 0011, 0111, 1011 main crystal with 256, 1k, 16k cycles
// - type field is frozen while the external source is system clock
// - fault bit 3 sets on pll lock loss when watched, write one clears
// - with fault bit 2 set a pll fault flag requests an nmi
// - fault bit 1 sets on external clock failure when watched, w1c
// - fault bit 0 starts the external monitor; only reset clears it
// - both watch enables change only through the protected write sequence
// - trim register loads a factory value on the first edge after reset release and stays writable
// - pll bits 7:6 pick input 00 2mhz, 10 32mhz, 11 external
// - pll bit 5 halves the pll output
// - pll bits 4:0 hold the multiplier, one to thirty-one
// - failure of the system clock source falls back to 2mhz with nmi
package ocr_pkg;
	// register offsets
	localparam logic [3:0] OFF_ENABLE = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h1;
	localparam logic [3:0] OFF_EXTCFG = 4'h2;
	localparam logic [3:0] OFF_FAULT = 4'h3;
	localparam logic [3:0] OFF_TRIM = 4'h4;
	localparam logic [3:0] OFF_PLL = 4'h5;
	// reset values and writable masks
	localparam logic [7:0] ENABLE_RESET = 8'h01;
	localparam logic [7:0] ENABLE_MASK = 8'h1f;
	localparam logic [7:0] EXTCFG_RESET = 8'h00;
	localparam logic [7:0] PLL_RESET = 8'h00;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	// field positions
	localparam int BIT_PLL = 4;
	localparam int BIT_EXT = 3;
	localparam int BIT_PLL_FLAG = 3;
	localparam int BIT_PLL_WATCH = 2;
	localparam int BIT_EXT_FLAG = 1;
	localparam int BIT_EXT_WATCH = 0;
	// system clock selection codes seen on the select input
	localparam logic [2:0] SEL_XOSC = 3'h3;
	localparam logic [2:0] SEL_PLL = 3'h4;
	// external source type codes
	localparam logic [3:0] TYPE_EXTCLK = 4'h0;
	localparam logic [3:0] TYPE_WATCH = 4'h2;
	localparam logic [3:0] TYPE_XTAL_256 = 4'h3;
	localparam logic [3:0] TYPE_XTAL_1K = 4'h7;
	localparam logic [3:0] TYPE_XTAL_16K = 4'hb;
	localparam logic [1:0] PLL_SRC_RESERVED = 2'h1;
	// start-up counts in source clock cycles
	localparam int START_EXTCLK = 6;
	localparam int START_256 = 256;
	localparam int START_1K = 1024;
	localparam int START_16K = 16384;
	// failure monitor timeout: no source edge for this long
	localparam int CLK_PERIOD_NS = 4;
	localparam int EXT_FAIL_TIME_NS = 100000;
	localparam int EXT_FAIL_CYCLES = EXT_FAIL_TIME_NS / CLK_PERIOD_NS;
	// external source start-up machine
	typedef enum logic [1:0] {
		EXT_OFF = 2'b00,
		EXT_STARTING = 2'b01,
		EXT_READY = 2'b10
	} ocr_ext_state_t;
endpackage : ocr_pkg

// ==== verif/ocr_oscillator_control_regs_tb_top.sv ====
// self-checking bench for the oscillator control register block
`timescale 1ns/1ps
module ocr_oscillator_control_regs_tb_top import ocr_pkg::*;;
	// short counts keep start-up and failure waits brief
	localparam int XTAL_SIM = 32;
	localparam int FAIL_SIM = 64;
	logic clk, reset_n, wrStrobe, rdStrobe, ccpOpen;
	logic [3:0] addr;
	logic [7:0] wrData, rdData, factoryTrim;
	logic [2:0] sysClkSel, rcStableRaw;
	logic pllLockRaw, extClkRaw;
	logic pllOn, extSourceOn, slowRcOn, fastRcOn, baseRcOn;
	logic [1:0] crystalBand, pllInputSelect;
	logic watchCrystalLowSwing, crystalHighDrive, pllHalfOutput;
	logic [3:0] extSourceType;
	logic [7:0] slowRcTrimValue;
	logic [4:0] pllMultiplier;
	logic nmiRequest, fallbackRequest;
	int errCount = 0;
	int cmpCount = 0;
	int fbCount = 0;
	logic [7:0] s;

	ocr_oscillator_control_regs #(.XTAL_16K_CYCLES(XTAL_SIM),
		.FAIL_CYCLES(FAIL_SIM)) i_dut (.clk(clk), .reset_n(reset_n),
		.addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .sysClkSel(sysClkSel),
		.ccpOpen(ccpOpen), .factoryTrim(factoryTrim),
		.pllLockRaw(pllLockRaw), .extClkRaw(extClkRaw),
		.rcStableRaw(rcStableRaw), .pllOn(pllOn),
		.extSourceOn(extSourceOn), .slowRcOn(slowRcOn),
		.fastRcOn(fastRcOn), .baseRcOn(baseRcOn),
		.crystalBand(crystalBand),
		.watchCrystalLowSwing(watchCrystalLowSwing),
		.crystalHighDrive(crystalHighDrive),
		.extSourceType(extSourceType),
		.slowRcTrimValue(slowRcTrimValue),
		.pllInputSelect(pllInputSelect), .pllHalfOutput(pllHalfOutput),
		.pllMultiplier(pllMultiplier), .nmiRequest(nmiRequest),
		.fallbackRequest(fallbackRequest));

	// 250 mhz clock
	always #2 clk = ~clk;

	// fallback is a one-cycle pulse, so count it at every edge
	always @(posedge clk)
		if (fallbackRequest === 1'b1)
			fbCount <= fbCount + 1;

	task automatic finalReport();
		if (errCount == 0 && cmpCount > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finalReport

	task automatic check(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		cmpCount++;
		if (got !== exp)
		begin
			errCount++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one-cycle write; the #1 lets the registered update land
	task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
		#1;
	endtask : wrReg

	// read data stand only in the cycle after the strobe
	task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		#1;
		s = rdData;
		check($sformatf("reg %h", a), exp, s);
	endtask : rdChk

	task automatic pollStatus(input logic [7:0] mask, input logic [7:0] exp);
		for (int i = 0; i < 300; i++)
		begin
			@(posedge clk);
			addr <= OFF_STATUS;
			rdStrobe <= 1'b1;
			@(posedge clk);
			rdStrobe <= 1'b0;
			#1;
			if ((rdData & mask) === exp)
				return;
		end
		check("status wait", exp, rdData & mask);
		finalReport();
	endtask : pollStatus

	task automatic waitNmi();
		for (int i = 0; i < 300; i++)
		begin
			@(posedge clk);
			#1;
			if (nmiRequest === 1'b1)
				return;
		end
		check("nmi wait", 8'h01, {7'h0, nmiRequest});
		finalReport();
	endtask : waitNmi

	// activity on the external source, four clocks per level
	task automatic edges(input int n);
		repeat (n)
		begin
			repeat (4) @(posedge clk);
			extClkRaw <= 1'b1;
			repeat (4) @(posedge clk);
			extClkRaw <= 1'b0;
		end
	endtask : edges

	task automatic testReset();
		rdChk(OFF_ENABLE, 8'h01);
		check("baseRcOn", 8'h01, {7'h0, baseRcOn});
		rdChk(OFF_STATUS, 8'h00);
		rdChk(OFF_PLL, 8'h00);
		rdChk(OFF_TRIM, 8'h5a);
		wrReg(OFF_STATUS, 8'h1f);
		rdChk(OFF_STATUS, 8'h00);
		wrReg(4'hf, 8'hff);
		rdChk(4'hf, 8'h00);
	endtask : testReset

	task automatic testEnable();
		wrReg(OFF_ENABLE, 8'h1f);
		rdChk(OFF_ENABLE, 8'h1f);
		check("enables", 8'h1f, {3'h0, pllOn, extSourceOn, slowRcOn,
			fastRcOn, baseRcOn});
		wrReg(OFF_ENABLE, 8'h01);
		check("enables", 8'h01, {3'h0, pllOn, extSourceOn, slowRcOn,
			fastRcOn, baseRcOn});
	endtask : testEnable

	task automatic testStatus();
		rcStableRaw <= 3'b111;
		pllLockRaw <= 1'b1;
		wrReg(OFF_PLL, 8'h02);
		wrReg(OFF_ENABLE, 8'h17);
		pollStatus(8'h17, 8'h17);
		wrReg(OFF_ENABLE, 8'h05);
		repeat (8) @(posedge clk);
		rdChk(OFF_STATUS, 8'h05);
		wrReg(OFF_ENABLE, 8'h17);
		pollStatus(8'h17, 8'h17);
		wrReg(OFF_ENABLE, 8'h01);
		pllLockRaw <= 1'b0;
	endtask : testStatus

	task automatic testPll();
		wrReg(OFF_PLL, 8'ha5);
		check("pll", 8'ha5, {pllInputSelect, pllHalfOutput,
			pllMultiplier});
		wrReg(OFF_PLL, 8'hff);
		rdChk(OFF_PLL, 8'hff);
		wrReg(OFF_PLL, 8'h41);
		check("pll src", 8'h03, {6'h0, pllInputSelect});
		wrReg(OFF_PLL, 8'h00);
		check("pll src", 8'h00, {6'h0, pllInputSelect});
		wrReg(OFF_TRIM, 8'hc3);
		rdChk(OFF_TRIM, 8'hc3);
		check("trim", 8'hc3, slowRcTrimValue);
	endtask : testPll

	task automatic testPllFault();
		wrReg(OFF_FAULT, 8'h04);
		rdChk(OFF_FAULT, 8'h00);
		ccpOpen <= 1'b1;
		wrReg(OFF_FAULT, 8'h04);
		ccpOpen <= 1'b0;
		rdChk(OFF_FAULT, 8'h04);
		pllLockRaw <= 1'b1;
		wrReg(OFF_ENABLE, 8'h11);
		pollStatus(8'h10, 8'h10);
		sysClkSel <= SEL_PLL;
		fbCount = 0;
		pllLockRaw <= 1'b0;
		waitNmi();
		rdChk(OFF_FAULT, 8'h0c);
		rdChk(OFF_ENABLE, 8'h01);
		check("fallbacks", 8'h01, 8'(fbCount));
		sysClkSel <= 3'h0;
		wrReg(OFF_FAULT, 8'h08);
		rdChk(OFF_FAULT, 8'h04);
		check("nmi", 8'h00, {7'h0, nmiRequest});
	endtask : testPllFault

	// fields per type code, then start-up counted in source edges
	task automatic testStartup();
		logic [3:0] types [5];
		int counts [5];
		logic [7:0] v;
		types = '{TYPE_EXTCLK, TYPE_XTAL_256, TYPE_XTAL_1K, TYPE_XTAL_16K,
			TYPE_WATCH};
		counts = '{6, 256, 1024, XTAL_SIM, XTAL_SIM};
		for (int i = 0; i < 5; i++)
		begin
			v = {2'(i), i[0], ~i[0], types[i]};
			wrReg(OFF_EXTCFG, v);
			check("extcfg", v, {crystalBand, watchCrystalLowSwing,
				crystalHighDrive, extSourceType});
			wrReg(OFF_ENABLE, 8'h09);
			edges(counts[i] - 2);
			repeat (8) @(posedge clk);
			rdChk(OFF_STATUS, 8'h01);
			edges(4);
			pollStatus(8'h08, 8'h08);
			wrReg(OFF_ENABLE, 8'h01);
		end
	endtask : testStartup

	task automatic testExtFault();
		wrReg(OFF_EXTCFG, 8'h00);
		wrReg(OFF_ENABLE, 8'h09);
		edges(8);
		pollStatus(8'h08, 8'h08);
		sysClkSel <= SEL_XOSC;
		wrReg(OFF_EXTCFG, 8'h07);
		check("type", 8'h00, {4'h0, extSourceType});
		fbCount = 0;
		ccpOpen <= 1'b1;
		wrReg(OFF_FAULT, 8'h05);
		wrReg(OFF_FAULT, 8'h04);
		ccpOpen <= 1'b0;
		waitNmi();
		rdChk(OFF_FAULT, 8'h07);
		rdChk(OFF_ENABLE, 8'h01);
		check("fallbacks", 8'h01, 8'(fbCount));
		sysClkSel <= 3'h0;
		wrReg(OFF_FAULT, 8'h02);
		rdChk(OFF_FAULT, 8'h05);
		check("nmi", 8'h00, {7'h0, nmiRequest});
		// a failing source that is not the system clock is only stopped
		fbCount = 0;
		wrReg(OFF_ENABLE, 8'h0b);
		edges(8);
		pollStatus(8'h08, 8'h08);
		waitNmi();
		rdChk(OFF_ENABLE, 8'h03);
		check("fallbacks", 8'h00, 8'(fbCount));
		wrReg(OFF_FAULT, 8'h02);
		check("nmi", 8'h00, {7'h0, nmiRequest});
	endtask : testExtFault

	// reset held ten cycles, then the scenarios in turn
	initial
	begin
		clk = 1'b0;
		reset_n = 1'b0;
		addr = 4'h0;
		wrData = 8'h00;
		wrStrobe = 1'b0;
		rdStrobe = 1'b0;
		sysClkSel = 3'h0;
		ccpOpen = 1'b0;
		factoryTrim = 8'h5a;
		pllLockRaw = 1'b0;
		extClkRaw = 1'b0;
		rcStableRaw = 3'b000;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		testReset();
		testEnable();
		testStatus();
		testPll();
		testPllFault();
		testStartup();
		testExtFault();
		finalReport();
	end
endmodule : ocr_oscillator_control_regs_tb_top
